// ==== design/asx_params.svh ====
// constants of the asynchronous serial transmitter block: offsets, fields, counts
// assumes a 40 MHz bus clock and a classic wishbone slave with 32-bit data
`ifndef ASX_PARAMS_SVH
`define ASX_PARAMS_SVH

// ***********************************
// register byte offsets
// ***********************************
`define ASX_OFF_BDH 8'h00
`define ASX_OFF_BDL 8'h04
`define ASX_OFF_C1 8'h08
`define ASX_OFF_C2 8'h0c
`define ASX_OFF_S1 8'h10
`define ASX_OFF_S2 8'h14
`define ASX_OFF_C3 8'h18
`define ASX_OFF_DAT 8'h1c

// ***********************************
// reset values and writable masks
// ***********************************
`define ASX_SBR_RST 13'h0004
`define ASX_BDH_MASK 8'h1f
`define ASX_C1_MASK 8'h13
`define ASX_C2_MASK 8'h0d
`define ASX_S2_MASK 8'h04
`define ASX_C3_MASK 8'h5f
`define ASX_TC_RST 1'b1

// ***********************************
// field positions
// ***********************************
`define ASX_C1_NINE 4
`define ASX_C1_PAR_ON 1
`define ASX_C1_PAR_ODD 0
`define ASX_C2_TXEN 3
`define ASX_C2_RXEN 2
`define ASX_C2_BRKSEND 0
`define ASX_S2_LONGBRK 2
`define ASX_C3_NINTH 6
`define ASX_C3_INVERT 4
`define ASX_C3_ERR_HI 3

// ***********************************
// frame lengths and sample timing
// ***********************************
`define ASX_LEN8 4'ha
`define ASX_LEN9 4'hb
`define ASX_BRK_S8 4'ha
`define ASX_BRK_S9 4'hb
`define ASX_BRK_L8 4'hd
`define ASX_BRK_L9 4'he
`define ASX_LEFT_LAST 4'h1
`define ASX_SHIFT_ONES 14'h3fff
`define ASX_SHIFT_ZERO 14'h0000
`define ASX_DIV_LAST 4'hf
`define ASX_RT_A 4'h7
`define ASX_RT_C 4'h9
`define ASX_RT_LATE 4'ha
`define ASX_RT_RESYNC 4'h1
`define ASX_RT_WRAP 4'hf
`define ASX_ONES_FULL 2'h3
`define ASX_STOP8 4'h9
`define ASX_STOP9 4'ha

`endif

// ==== design/asx_pkg.sv ====
// types of the asynchronous serial transmitter block
// assumes nothing beyond a systemverilog compiler
package asx_pkg;
  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } asx_wb_req_type;
  // wishbone answer of the slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } asx_wb_rsp_type;
  typedef enum logic {TX_IDLE, TX_SHIFT} asx_tx_state_type;
  typedef enum logic {RX_IDLE, RX_FRAME} asx_rx_state_type;
  typedef enum logic [1:0] {FR_NONE, FR_IDLE, FR_BREAK, FR_DATA} asx_frame_type;
endpackage

// ==== design/asx_sync2.sv ====
// two-flop synchroniser for the serial input pin
// assumes the pin idles high, so both stages reset high
`timescale 1ns/1ps
`default_nettype none
module asx_sync2 (
  // system
  input wire logic clk,
  input wire logic rst,
  // pin side and clock side
  input wire logic pinIn,
  output logic syncOut
);
  logic meta;

  // the first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b1;
      syncOut <= 1'b1;
    end else begin
      meta <= pinIn;
      syncOut <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== design/asx_baud_gen.sv ====
// modulo baud divider giving a one-cycle pulse at sixteen times the bit rate
// assumes the bus clock; a divisor of zero stops the pulses
`timescale 1ns/1ps
`default_nettype none
module asx_baud_gen (
  // system
  input wire logic clk,
  input wire logic rst,
  // divisor and rate pulse
  input wire logic [12:0] divisor,
  output logic tick16
);
  logic [12:0] count;

  // count 1..divisor, pulse on the last count
  always_ff @(posedge clk) begin
    if (rst || divisor == 13'h0000) begin
      count <= 13'h0001;
      tick16 <= 1'b0;
    end else if (count >= divisor) begin
      count <= 13'h0001;
      tick16 <= 1'b1;
    end else begin
      count <= count + 13'h0001;
      tick16 <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== design/asx_serial_tx.sv ====
// serial transmit path with shared baud generation, receive check and registers
// assumes a classic wishbone master on clk; rxPin comes from outside the domain
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "asx_params.svh"
module asx_serial_tx
  import asx_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire asx_wb_req_type wbReq,
  output var asx_wb_rsp_type wbRsp,
  // serial pins
  input wire logic rxPin,
  output logic txPin,
  output logic txOwn,
  // error interrupt request
  output logic errIrq
);
  // ***********************************
  // declarations
  // ***********************************
  logic acc, wrAcc, rdAcc, dataWr, dataRd, stsRd;
  logic [7:0] adr, wd, rdData;
  logic [12:0] sbr;
  logic [7:0] ctlOne, ctlTwo, stsTwo, ctlThree;
  logic nineBit, txEnable, rxEnable, sendBreak, longBreak, txInvert;
  logic teRise, sbkRise;
  logic tick16, bitTick, rxS, rxPrev, fallNow;
  logic [3:0] txDiv;
  logic [7:0] txBuf;
  logic txFull, tc, tcArmed, idleQ, breakQ, lineNow, frameEnd;
  asx_tx_state_type txState;
  asx_rx_state_type rxState;
  asx_frame_type nextFrame;
  logic [13:0] txShift, dataPat;
  logic [3:0] txLeft, frameLen, brkLen;
  logic [1:0] onesCnt, samp;
  logic [3:0] rt, rxIdx, stopIdx;
  logic [8:0] rxShift;
  logic noisy, bitv, allEq, rxDone, rxArmed;
  logic rdrf, overrun, noiseFlag, frameErr, parityErr, rx9;
  logic [7:0] rxBuf;
  logic [3:0] errVec;

  // decode shared by writes, reads and the flag sequences
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ***********************************
  // wishbone slave
  // ***********************************
  // ack never stands in two cycles running, so each request is taken once
  assign acc = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
  assign wrAcc = acc & wbReq.we & wbReq.sel[0];
  assign rdAcc = acc & ~wbReq.we;
  assign adr = wbReq.adr;
  assign wd = wbReq.dat[7:0];
  assign dataWr = wrAcc & hit(adr, `ASX_OFF_DAT);
  assign dataRd = rdAcc & hit(adr, `ASX_OFF_DAT);
  assign stsRd = rdAcc & hit(adr, `ASX_OFF_S1);

  // one wait state; unmapped offsets answer with zero data
  always_ff @(posedge clk) begin
    if (rst) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= acc;
      wbRsp.dat <= rdAcc ? {24'h000000, rdData} : 32'h00000000;
    end
  end

  sequence sqAckPulse;
    wbRsp.ack ##1 !wbRsp.ack;
  endsequence
  AST_WB_ACK: assert property (acc |=> sqAckPulse)
    else $error("bus answer is not a single ack pulse");

  // read mux; the data address returns the receive side only
  always_comb begin
    rdData = 8'h00;
    if (hit(adr, `ASX_OFF_BDH)) begin
      rdData = {3'h0, sbr[12:8]};
    end else if (hit(adr, `ASX_OFF_BDL)) begin
      rdData = sbr[7:0];
    end else if (hit(adr, `ASX_OFF_C1)) begin
      rdData = ctlOne;
    end else if (hit(adr, `ASX_OFF_C2)) begin
      rdData = ctlTwo;
    end else if (hit(adr, `ASX_OFF_S1)) begin
      rdData = {~txFull, tc, rdrf, 1'b0, overrun, noiseFlag, frameErr, parityErr};
    end else if (hit(adr, `ASX_OFF_S2)) begin
      rdData = stsTwo;
    end else if (hit(adr, `ASX_OFF_C3)) begin
      rdData = {rx9, ctlThree[6:0]};
    end else if (hit(adr, `ASX_OFF_DAT)) begin
      rdData = rxBuf;
    end
  end

  // ***********************************
  // control registers
  // ***********************************
  // reserved bits are masked on write so they read back as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sbr <= `ASX_SBR_RST;
      ctlOne <= 8'h00;
      ctlTwo <= 8'h00;
      stsTwo <= 8'h00;
      ctlThree <= 8'h00;
    end else if (wrAcc) begin
      if (hit(adr, `ASX_OFF_BDH)) begin
        sbr[12:8] <= wd[4:0];
      end
      if (hit(adr, `ASX_OFF_BDL)) begin
        sbr[7:0] <= wd;
      end
      if (hit(adr, `ASX_OFF_C1)) begin
        ctlOne <= wd & `ASX_C1_MASK;
      end
      if (hit(adr, `ASX_OFF_C2)) begin
        ctlTwo <= wd & `ASX_C2_MASK;
      end
      if (hit(adr, `ASX_OFF_S2)) begin
        stsTwo <= wd & `ASX_S2_MASK;
      end
      if (hit(adr, `ASX_OFF_C3)) begin
        ctlThree <= wd & `ASX_C3_MASK;
      end
    end
  end

  assign nineBit = ctlOne[`ASX_C1_NINE];
  assign txEnable = ctlTwo[`ASX_C2_TXEN];
  assign rxEnable = ctlTwo[`ASX_C2_RXEN];
  assign sendBreak = ctlTwo[`ASX_C2_BRKSEND];
  assign longBreak = stsTwo[`ASX_S2_LONGBRK];
  assign txInvert = ctlThree[`ASX_C3_INVERT];
  // a zero-to-one write queues an idle or a break frame; send-break still set at a break load queues another
  assign teRise = wrAcc & hit(adr, `ASX_OFF_C2) & wd[`ASX_C2_TXEN] & ~txEnable;
  assign sbkRise = wrAcc & hit(adr, `ASX_OFF_C2) & wd[`ASX_C2_BRKSEND] & ~sendBreak;

  // ***********************************
  // baud timing
  // ***********************************
  // one divider feeds the receiver directly and the transmitter by sixteen
  asx_baud_gen baudGen (
    .clk(clk),
    .rst(rst),
    .divisor(sbr),
    .tick16(tick16)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      txDiv <= 4'h0;
    end else if (tick16) begin
      txDiv <= txDiv + 4'h1;
    end
  end
  assign bitTick = tick16 & (txDiv == `ASX_DIV_LAST);

  // ***********************************
  // transmitter
  // ***********************************
  assign frameLen = nineBit ? `ASX_LEN9 : `ASX_LEN8;
  // break length by long-break select and data length
  always_comb begin
    case ({longBreak, nineBit})
      2'b00: brkLen = `ASX_BRK_S8;
      2'b01: brkLen = `ASX_BRK_S9;
      2'b10: brkLen = `ASX_BRK_L8;
      default: brkLen = `ASX_BRK_L9;
    endcase
  end
  // start low, data lsb first, ninth bit or stop, then high fill
  assign dataPat = nineBit ? {3'h7, 1'b1, ctlThree[`ASX_C3_NINTH], txBuf, 1'b0}
                           : {4'hf, 1'b1, txBuf, 1'b0};

  // the shifter is free when idle or on the tick that ends its last bit
  always_comb begin
    nextFrame = FR_NONE;
    if (bitTick && (txState == TX_IDLE || txLeft == `ASX_LEFT_LAST)) begin
      if (idleQ) begin
        nextFrame = FR_IDLE;
      end else if (breakQ) begin
        nextFrame = FR_BREAK;
      end else if (txFull && txEnable) begin
        nextFrame = FR_DATA;
      end
    end
  end
  assign frameEnd = bitTick & (txState == TX_SHIFT) & (txLeft == `ASX_LEFT_LAST)
                    & (nextFrame == FR_NONE);

  // shifter; loads happen only on a bit tick so frames stay aligned
  always_ff @(posedge clk) begin
    if (rst) begin
      txState <= TX_IDLE;
      txShift <= `ASX_SHIFT_ONES;
      txLeft <= 4'h0;
    end else if (nextFrame != FR_NONE) begin
      txState <= TX_SHIFT;
      txLeft <= (nextFrame == FR_BREAK) ? brkLen : frameLen;
      case (nextFrame)
        FR_IDLE: txShift <= `ASX_SHIFT_ONES;
        FR_BREAK: txShift <= `ASX_SHIFT_ZERO;
        default: txShift <= dataPat;
      endcase
    end else if (bitTick && txState == TX_SHIFT) begin
      txShift <= {1'b1, txShift[13:1]};
      txLeft <= txLeft - 4'h1;
      if (txLeft == `ASX_LEFT_LAST) begin
        txState <= TX_IDLE;
      end
    end
  end

  // queued idle and break frames; a new request wins over the load clear
  always_ff @(posedge clk) begin
    if (rst) begin
      idleQ <= 1'b0;
      breakQ <= 1'b0;
    end else begin
      if (nextFrame == FR_IDLE) begin
        idleQ <= 1'b0;
      end
      if (nextFrame == FR_BREAK) begin
        breakQ <= sendBreak;
      end
      if (teRise) begin
        idleQ <= 1'b1;
      end
      if (sbkRise) begin
        breakQ <= 1'b1;
      end
    end
  end

  // transmit buffer; a write landing on the load cycle is kept, not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      txBuf <= 8'h00;
      txFull <= 1'b0;
    end else begin
      if (nextFrame == FR_DATA) begin
        txFull <= 1'b0;
      end
      if (dataWr) begin
        txBuf <= wd;
        txFull <= 1'b1;
      end
    end
  end

  // line level and pin ownership, both from flops
  assign lineNow = (txState == TX_SHIFT) ? txShift[0] : 1'b1;
  always_ff @(posedge clk) begin
    if (rst) begin
      txPin <= 1'b1;
      txOwn <= 1'b0;
    end else begin
      txPin <= lineNow ^ txInvert;
      txOwn <= txEnable | (txState == TX_SHIFT) | idleQ | breakQ;
    end
  end

  sequence sqIdleLoaded;
    (txState == TX_SHIFT) && (txShift == `ASX_SHIFT_ONES);
  endsequence
  sequence sqBreakLoaded;
    (txState == TX_SHIFT) && (txShift == `ASX_SHIFT_ZERO);
  endsequence
  AST_TX_INVERT: assert property ($stable(txInvert)
    |=> txPin == ($past(lineNow) ^ $past(txInvert)))
    else $error("serial output does not follow the inversion bit");
  AST_IDLE_HIGH: assert property ((txState == TX_IDLE && !txInvert) |=> txPin)
    else $error("idle line is not high with inversion off");
  AST_PREAMBLE: assert property (teRise |=> idleQ)
    else $error("enable write did not queue an idle frame");
  AST_IDLE_FRAME: assert property (nextFrame == FR_IDLE |=> sqIdleLoaded ##0 txLeft == $past(frameLen))
    else $error("queued idle frame has the wrong shape");
  AST_DATA_LEN: assert property (nextFrame == FR_DATA |=> txLeft == $past(frameLen) && !lineNow)
    else $error("data frame length or start bit wrong");
  AST_LOAD_EMPTY: assert property ((nextFrame == FR_DATA && !dataWr) |=> !txFull)
    else $error("buffer-empty did not set on load");
  AST_TC_SET: assert property (frameEnd |=> tc && txState == TX_IDLE)
    else $error("complete flag not set at end of last frame");
  AST_OWN_PIN: assert property ((txState == TX_SHIFT || idleQ || breakQ) |=> txOwn)
    else $error("pin released with activity pending");
  AST_BRK_AGAIN: assert property ((nextFrame == FR_BREAK && sendBreak) |=> breakQ)
    else $error("break not queued again while send-break stands");
  AST_BRK_LEN: assert property (nextFrame == FR_BREAK |=> sqBreakLoaded ##0 txLeft == $past(brkLen))
    else $error("break length does not match its setting");

  // ***********************************
  // receiver
  // ***********************************
  asx_sync2 rxSync (
    .clk(clk),
    .rst(rst),
    .pinIn(rxPin),
    .syncOut(rxS)
  );

  assign fallNow = rxPrev & ~rxS;
  assign stopIdx = nineBit ? `ASX_STOP9 : `ASX_STOP8;
  assign bitv = maj3({samp, rxS});
  assign allEq = (samp == {rxS, rxS});
  assign rxDone = tick16 & rxEnable & (rxState == RX_FRAME) & (rt == `ASX_RT_C)
                  & (rxIdx == stopIdx);

  // sixteen samples per bit, majority of the three middle ones
  always_ff @(posedge clk) begin
    if (rst) begin
      rxState <= RX_IDLE;
      rxPrev <= 1'b1;
      onesCnt <= 2'h0;
      samp <= 2'h0;
      rt <= 4'h0;
      rxIdx <= 4'h0;
      noisy <= 1'b0;
      rxShift <= 9'h000;
    end else if (tick16 && rxEnable) begin
      rxPrev <= rxS;
      case (rxState)
        RX_IDLE: begin
          // a start edge is a low sample after three high ones
          if (!rxS && onesCnt == `ASX_ONES_FULL) begin
            rxState <= RX_FRAME;
            rt <= `ASX_RT_RESYNC;
            rxIdx <= 4'h0;
            noisy <= 1'b0;
          end
          if (!rxS) begin
            onesCnt <= 2'h0;
          end else if (onesCnt != `ASX_ONES_FULL) begin
            onesCnt <= onesCnt + 2'h1;
          end
        end
        RX_FRAME: begin
          samp <= {samp[0], rxS};
          // a falling edge late in a bit starts the next bit at once
          if (fallNow && rt >= `ASX_RT_LATE) begin
            rt <= `ASX_RT_RESYNC;
            rxIdx <= rxIdx + 4'h1;
          end else if (fallNow && rt < `ASX_RT_A) begin
            rt <= `ASX_RT_RESYNC;
          end else begin
            rt <= rt + 4'h1;
            if (rt == `ASX_RT_WRAP) begin
              rxIdx <= rxIdx + 4'h1;
            end
          end
          if (rt == `ASX_RT_C) begin
            noisy <= noisy | ~allEq;
            if (rxIdx == 4'h0) begin
              if (bitv) begin
                rxState <= RX_IDLE; // false start
              end
            end else if (rxIdx == stopIdx) begin
              rxState <= RX_IDLE;
              // after a break wait for three highs; otherwise restart fast
              onesCnt <= (rxShift == 9'h000 && !bitv) ? 2'h0 : `ASX_ONES_FULL;
            end else begin
              rxShift <= {bitv, rxShift[8:1]};
            end
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  AST_RESYNC: assert property ((tick16 && rxEnable && rxState == RX_FRAME && fallNow
    && rt >= `ASX_RT_LATE) |=> rt == `ASX_RT_RESYNC)
    else $error("receiver did not resynchronise on a falling edge");

  // ***********************************
  // status flags
  // ***********************************
  // flags clear by a status read then a data access; a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      rdrf <= 1'b0;
      overrun <= 1'b0;
      noiseFlag <= 1'b0;
      frameErr <= 1'b0;
      parityErr <= 1'b0;
      rxBuf <= 8'h00;
      rx9 <= 1'b0;
      rxArmed <= 1'b0;
      tc <= `ASX_TC_RST;
      tcArmed <= 1'b0;
    end else begin
      if (stsRd) begin
        rxArmed <= rdrf | overrun | noiseFlag | frameErr | parityErr;
        tcArmed <= tc;
      end
      if (dataRd && rxArmed) begin
        rdrf <= 1'b0;
        overrun <= 1'b0;
        noiseFlag <= 1'b0;
        frameErr <= 1'b0;
        parityErr <= 1'b0;
        rxArmed <= 1'b0;
      end
      if (dataWr && tcArmed) begin
        tc <= 1'b0;
        tcArmed <= 1'b0;
      end
      if (frameEnd) begin
        tc <= 1'b1;
      end
      // a held framing error blocks transfers until it is cleared
      if (rxDone && rdrf) begin
        overrun <= 1'b1;
      end else if (rxDone && !frameErr) begin
        rxBuf <= nineBit ? rxShift[7:0] : rxShift[8:1];
        rx9 <= rxShift[8];
        rdrf <= 1'b1;
        noiseFlag <= noisy | ~allEq;
        frameErr <= ~bitv;
        parityErr <= ctlOne[`ASX_C1_PAR_ON]
                     & ((^(nineBit ? rxShift : {1'b0, rxShift[8:1]})) != ctlOne[`ASX_C1_PAR_ODD]);
      end
    end
  end

  AST_FLAG_CLEAR: assert property ((dataRd && rxArmed && !rxDone) |=> !rdrf && !frameErr)
    else $error("data read did not finish the flag clearing");
  AST_DATA_SPLIT: assert property ((dataWr && !rxDone) |=> txBuf == $past(wd) && $stable(rxBuf))
    else $error("data write touched the receive buffer");
  AST_BREAK_RX: assert property ((rxDone && !rdrf && !frameErr && !bitv
    && rxShift == 9'h000) |=> frameErr && rxBuf == 8'h00)
    else $error("received break not reported as zero data with framing error");

  // ***********************************
  // error interrupt
  // ***********************************
  // the four error sources share this one request line
  assign errVec = {overrun, noiseFlag, frameErr, parityErr} & ctlThree[`ASX_C3_ERR_HI:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      errIrq <= 1'b0;
    end else begin
      errIrq <= |errVec;
    end
  end

  AST_ERR_ON: assert property (|errVec |=> errIrq)
    else $error("enabled error flag gave no interrupt request");
  AST_ERR_OFF: assert property (errVec == 4'h0 |=> !errIrq)
    else $error("interrupt request without an enabled error flag");
endmodule
`default_nettype wire

// ==== verif/asx_remote_model.sv ====
// remote serial peer: decodes the transmit line and drives the receive line
// assumes a divisor of one, so one bit lasts sixteen clocks
`timescale 1ns/1ps
`default_nettype none
module asx_remote_model (
  // clock and lines
  input wire logic clk,
  input wire logic line,
  input wire logic inv,
  output logic rxLine,
  // decoded character
  output logic gotByte,
  output logic [7:0] byteVal
);
  // ****************************
  // sender and decoder
  // ****************************
  initial begin
    rxLine = 1'b1;
    gotByte = 1'b0;
    byteVal = 8'h00;
  end
  // low start, lsb first, stop; zero data with a low stop makes a break
  task automatic sendFrame(input logic [7:0] d, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, d, 1'b0};
    for (int k = 0; k < 10; k++) begin
      rxLine <= f[k];
      repeat (16) @(posedge clk); // same rate as the device
    end
    rxLine <= 1'b1;
  endtask
  // decoder; a low shorter than half a bit is a glitch, not a start
  always begin
    @(posedge clk);
    gotByte <= 1'b0;
    if ((line ^ inv) === 1'b0) begin
      repeat (8) @(posedge clk);
      if ((line ^ inv) === 1'b0) begin
        for (int k = 0; k < 8; k++) begin
          repeat (16) @(posedge clk);
          byteVal[k] <= line ^ inv;
        end
        repeat (16) @(posedge clk);
        gotByte <= line ^ inv; // only a high stop bit counts
        for (int j = 0; j < 400 && (line ^ inv) !== 1'b1; j++) @(posedge clk);
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/async_serial_transmitter_tb.sv ====
// self-checking bench of the serial transmitter top
// assumes divisor one and the remote model on both serial lines
`timescale 1ns/1ps
`default_nettype none
module async_serial_transmitter_tb;
  import asx_pkg::*;
  logic clk, rst, rxPin, txPin, txOwn, errIrq, inv, got;
  logic [7:0] rb, b;
  logic [31:0] lastRd;
  asx_wb_req_type wbReq;
  asx_wb_rsp_type wbRsp;
  int nMismatch, checked;
  logic [31:0] expR[$];
  logic [7:0] expT[$];
  asx_serial_tx i_dut (.clk(clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp),
    .rxPin(rxPin), .txPin(txPin), .txOwn(txOwn), .errIrq(errIrq));
  // the shared pin is parked high as a plain output whenever the block lets go
  wire logic pinLine;
  assign pinLine = txOwn ? txPin : 1'b1;
  asx_remote_model i_rm (.clk(clk), .line(pinLine), .inv(inv), .rxLine(rxPin),
    .gotByte(got), .byteVal(rb));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************
  // tasks
  // ****************************
  task automatic complete_run;
    if (nMismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      nMismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // a used-up wait counts as a mismatch and ends the run
  task automatic bail(input logic hit);
    if (hit) begin
      nMismatch++;
      complete_run();
    end
  endtask
  // classic cycle held until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    wbReq <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge clk);
      i++;
    end while (wbRsp.ack !== 1'b1 && i < 20);
    lastRd = wbRsp.dat;
    if (i >= 20) begin
      nMismatch++;
      complete_run();
    end
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expR.push_back(e);
    wb(1'b0, a, 8'h00);
  endtask
  // the buffer holds one byte, so poll buffer-empty before each data write
  task automatic tx(input logic [7:0] d);
    int i;
    i = 0;
    do begin
      wb(1'b0, 8'h10, 8'h00);
      i++;
    end while (lastRd[7] !== 1'b1 && i < 400);
    bail(lastRd[7] !== 1'b1);
    expT.push_back(d);
    wb(1'b1, 8'h1c, d);
  endtask
  task automatic waitIdle;
    int i;
    for (i = 0; i < 3000 && expT.size() > 0; i++) @(posedge clk);
    bail(i >= 3000);
    repeat (20) @(posedge clk);
  endtask
  // break with buffer empty, low run measured on the pin
  // an idle frame goes first so the send-break pair lands while the shifter is busy
  task automatic brk(input logic [7:0] c1, input logic [7:0] s2, input int e, input logic hold);
    int i, n;
    i = 0;
    n = 0;
    wb(1'b1, 8'h08, c1);
    wb(1'b1, 8'h14, s2);
    wb(1'b1, 8'h0c, 8'h04);
    wb(1'b1, 8'h0c, 8'h0c);
    wb(1'b1, 8'h0c, 8'h0d);
    if (!hold) wb(1'b1, 8'h0c, 8'h0c);
    while (txPin !== 1'b0 && i < 400) begin
      @(posedge clk);
      i++;
    end
    bail(txPin !== 1'b0);
    // send-break still set at load queues a second break
    fork
      while (txPin === 1'b0 && n < 600) begin
        @(posedge clk);
        n++;
      end
      if (hold) wb(1'b1, 8'h0c, 8'h0c);
    join
    chk(32'(n), 32'(e));
    repeat (40) @(posedge clk);
  endtask
  // monitor: oldest note against each result
  always @(posedge clk) begin
    if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0 && expR.size() > 0)
      chk(wbRsp.dat, expR.pop_front());
    if (got === 1'b1 && expT.size() > 0) chk({24'h0, rb}, {24'h0, expT.pop_front()});
  end
  // ****************************
  // main sequence
  // ****************************
  initial begin
    nMismatch = 0;
    checked = 0;
    rst = 1'b1;
    inv = 1'b0;
    wbReq = '0;
    void'($urandom(32'h58d963b9));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, txPin}, 32'h1);
    rd(8'h18, 32'h0);
    rd(8'h40, 32'h0);
    wb(1'b1, 8'h04, 8'h01);
    wb(1'b1, 8'h0c, 8'h0c);
    repeat (150) begin
      @(posedge clk);
      chk({31'h0, txPin}, 32'h1);
    end
    for (int k = 0; k < 3; k++) tx(8'($urandom));
    waitIdle();
    rd(8'h10, 32'hc0);
    wb(1'b1, 8'h18, 8'h10);
    inv <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, txPin}, 32'h0);
    tx(8'($urandom));
    waitIdle();
    wb(1'b1, 8'h18, 8'h00);
    inv <= 1'b0;
    brk(8'h00, 8'h00, 160, 1'b0);
    brk(8'h10, 8'h00, 176, 1'b0);
    brk(8'h00, 8'h04, 208, 1'b0);
    brk(8'h10, 8'h04, 224, 1'b0);
    brk(8'h00, 8'h00, 320, 1'b1);
    wb(1'b1, 8'h08, 8'h00);
    tx(8'($urandom));
    repeat (20) @(posedge clk);
    wb(1'b1, 8'h0c, 8'h04);
    chk({31'h0, txOwn}, 32'h1);
    waitIdle();
    chk({31'h0, txOwn}, 32'h0);
    b = 8'($urandom);
    i_rm.sendFrame(b, 1'b1);
    repeat (40) @(posedge clk);
    wb(1'b0, 8'h10, 8'h00);
    rd(8'h1c, {24'h0, b});
    wb(1'b1, 8'h18, 8'h02);
    i_rm.sendFrame(8'h00, 1'b0);
    repeat (40) @(posedge clk);
    chk({31'h0, errIrq}, 32'h1);
    wb(1'b0, 8'h10, 8'h00);
    rd(8'h1c, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, errIrq}, 32'h0);
    wb(1'b1, 8'h18, 8'h00);
    i_rm.sendFrame(8'h00, 1'b0);
    repeat (40) @(posedge clk);
    chk({31'h0, errIrq}, 32'h0);
    rd(8'h10, 32'he2);
    wb(1'b1, 8'h18, 8'h08);
    i_rm.sendFrame(b, 1'b1);
    repeat (40) @(posedge clk);
    chk({31'h0, errIrq}, 32'h1);
    rd(8'h10, 32'hea);
    rd(8'h1c, 32'h0);
    wb(1'b1, 8'h08, 8'h02);
    wb(1'b1, 8'h18, 8'h01);
    i_rm.sendFrame(8'h01, 1'b1);
    repeat (40) @(posedge clk);
    chk({31'h0, errIrq}, 32'h1);
    rd(8'h10, 32'he1);
    complete_run();
  end
endmodule
`default_nettype wire
